/* gdc_pkg.sv */
// package: constants and types for the gate driver serial control port and power states
// Functional notes
// [RULE1] controller keeps clock low at select edges
// [RULE2] controller raises select between 16-bit words
// [RULE3] deselected: ignore clock/data, output tri-stated
// [RULE4] sample on falling edge, shift on rising
// [RULE5] words travel most significant bit first
// [RULE6] exactly 16 clocks else discard, flag error
// [RULE7] word: zero, read flag, address, data
// [RULE8] read flag one reads, zero writes
// [RULE9] second byte: old or current register contents
// [RULE10] first byte: 11 then six summary flags
// [RULE11] wake low or supply lost: sleep, drivers off
// [RULE12] leaving sleep restores register defaults
// [RULE13] standby after wake delay, drivers off
// [RULE14] operating needs wake, logic and power supply
// [RULE15] serial variant: drivers wait for enable bit
// [RULE16] pin variant: drivers enable automatically
// [RULE17] kill pin or enable bit low: gates down
// [RULE18] separate selects per device unless chained; tb drives two unchained devices from one select
// [RULE19] latched fault holds until clear command
// [RULE20] status byte captured at select fall
// [RULE21] write commits at select rise, valid frame
package gdc_pkg;
	localparam int          GDC_FRAME_BITS   = 16;
	localparam int          GDC_ADDR_W       = 6;
	localparam int          GDC_REG_DEPTH    = 64;
	localparam int          GDC_WAKE_NS      = 1000;
	localparam int          GDC_CLK_MHZ      = 25;
	localparam int          GDC_WAKE_CYC     = (GDC_WAKE_NS * GDC_CLK_MHZ + 999) / 1000;
	localparam logic [5:0]  GDC_CTRL_ADDR    = 6'h07;
	localparam int          GDC_DRV_ENABLE_BIT = 7;
	localparam int          GDC_CLEAR_FAULTS_BIT = 0;
	localparam logic [1:0]  GDC_STAT_TOP     = 2'h3;
	localparam logic [7:0]  GDC_REG_RESET    = 8'h00;
	localparam logic [4:0]  GDC_CNT_RESET    = 5'h00;

	typedef enum logic [1:0] {
		GDC_SLEEP   = 2'b00,
		GDC_WAKING  = 2'b01,
		GDC_STANDBY = 2'b11,
		GDC_OPERATE = 2'b10
	} gdc_state_t;

	typedef struct packed {
		logic shutdown;
		logic alert;
		logic mosfet_monitor_flag;
		logic supply_low_flag;
		logic supply_high_flag;
		logic thermal_watchdog_flag;
	} gdc_flags_t;

	typedef struct packed {
		logic                  zero;
		logic                  read_flag;
		logic [GDC_ADDR_W-1:0] addr;
		logic [7:0]            data;
	} gdc_cmd_t;
endpackage

/* gdc_regmem.sv */
// register storage with registered read data
`timescale 1ns/10ps
module gdc_regmem
	import gdc_pkg::*;
#(
	parameter int DEPTH = GDC_REG_DEPTH,
	parameter int AW    = GDC_ADDR_W
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_n_i,
	input  wire logic          clear_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem [DEPTH];

	// clear wipes every word so a wake starts from defaults
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= GDC_REG_RESET;
			rdata_o <= GDC_REG_RESET;
		end else if (clear_i) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= GDC_REG_RESET; // [RULE12]
			rdata_o <= GDC_REG_RESET;
		end else begin
			if (we_i) mem[waddr_i] <= wdata_i;
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

/* gdc_serial_ctrl.sv */
// serial control port, power states and gate drive enable
`timescale 1ns/10ps
module gdc_serial_ctrl
	import gdc_pkg::*;
#(
	parameter bit PIN_VARIANT = 1'b0
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       chip_select_n_i,
	input  wire logic       sclk_i,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	output logic            sdo_oe_o,
	input  wire logic       wake_pin_i,
	input  wire logic       logic_supply_ok_i,
	input  wire logic       power_supply_ok_i,
	input  wire logic       driver_kill_pin_i,
	input  wire gdc_flags_t fault_causes_i,
	output gdc_flags_t      fault_flags_o,
	output logic            frame_length_error_o,
	output gdc_state_t      state_o,
	output logic            core_active_o,
	output logic            charge_pump_on_o,
	output logic            gate_drive_on_o,
	output logic            gate_pulldown_o
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic       cs_s1, cs_s2;
	logic       ck_s1, ck_s2;
	logic       di_s1, di_s2;
	logic [2:0] lv_s1, lv_s2;
	logic       cs_q, ck_q;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			di_s1 <= 1'b0;
			di_s2 <= 1'b0;
			lv_s1 <= 3'h0;
			lv_s2 <= 3'h0;
			cs_q  <= 1'b1;
			ck_q  <= 1'b0;
		end else begin
			cs_s1 <= chip_select_n_i;
			cs_s2 <= cs_s1;
			ck_s1 <= sclk_i;
			ck_s2 <= ck_s1;
			di_s1 <= sdi_i;
			di_s2 <= di_s1;
			lv_s1 <= {wake_pin_i, logic_supply_ok_i, driver_kill_pin_i};
			lv_s2 <= lv_s1;
			cs_q  <= cs_s2;
			ck_q  <= ck_s2;
		end
	end

	wire cs_n            = cs_s2;
	wire cs_fall         = cs_q & ~cs_n;
	wire cs_rise         = ~cs_q & cs_n;
	wire selected        = ~cs_n;
	// clock edges only count while selected
	wire ck_fall         = selected & ck_q & ~ck_s2; // [RULE3]
	wire ck_rise         = selected & ~ck_q & ck_s2; // [RULE3]
	wire wake            = lv_s2[2];
	wire logic_supply_ok = lv_s2[1];
	wire kill            = lv_s2[0];
	// power supply flag treated as a slow level, synchronised with the rest
	// fault causes come from analog monitors, so they are synchronised too
	logic       pv_s1, pv_s2;
	gdc_flags_t fc_s1, fc_s2;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pv_s1 <= 1'b0;
			pv_s2 <= 1'b0;
			fc_s1 <= '0;
			fc_s2 <= '0;
		end else begin
			pv_s1 <= power_supply_ok_i;
			pv_s2 <= pv_s1;
			fc_s1 <= fault_causes_i;
			fc_s2 <= fc_s1;
		end
	end

	// ****************************************
	// power states
	// ****************************************
	gdc_state_t state, next_state;
	logic [7:0] wake_cnt;
	wire        asleep = ~wake | ~logic_supply_ok; // [RULE11]

	always_comb begin
		next_state = state;
		case (state)
			GDC_SLEEP:   next_state = asleep ? GDC_SLEEP : GDC_WAKING;
			GDC_WAKING:  next_state = asleep ? GDC_SLEEP :
				(wake_cnt == 8'(GDC_WAKE_CYC - 1)) ? GDC_STANDBY : GDC_WAKING; // [RULE13]
			GDC_STANDBY: next_state = asleep ? GDC_SLEEP :
				pv_s2 ? GDC_OPERATE : GDC_STANDBY; // [RULE14]
			GDC_OPERATE: next_state = asleep ? GDC_SLEEP :
				pv_s2 ? GDC_OPERATE : GDC_STANDBY; // [RULE14]
			default:     next_state = GDC_SLEEP;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= GDC_SLEEP;
			wake_cnt <= 8'h00;
		end else begin
			state    <= next_state;
			wake_cnt <= (state == GDC_WAKING) ? wake_cnt + 8'h01 : 8'h00;
		end
	end

	wire port_on   = (state == GDC_STANDBY) || (state == GDC_OPERATE);
	// registers held at defaults whenever asleep
	wire reg_clear = (state == GDC_SLEEP); // [RULE12]

	// ****************************************
	// serial frame
	// ****************************************
	logic [15:0] shin, shout;
	logic [4:0]  bitcnt;
	logic        frame_ok_q;
	gdc_flags_t  flags;
	gdc_cmd_t    cmd;
	logic [7:0]  rdata;
	logic        load_arm;
	logic        load_report;
	localparam logic [7:0] CLR_MASK = 8'(1 << GDC_CLEAR_FAULTS_BIT);

	assign cmd = gdc_cmd_t'(shin);
	wire frame_ok = (bitcnt == 5'(GDC_FRAME_BITS)); // [RULE6]
	wire do_write = port_on & cs_rise & frame_ok & ~cmd.zero & ~cmd.read_flag; // [RULE21] [RULE8]
	wire ctrl_hit = (cmd.addr == GDC_CTRL_ADDR);
	wire clr_cmd  = do_write & ctrl_hit & cmd.data[GDC_CLEAR_FAULTS_BIT];
	// the clear bit is a command, so it is never stored and never reads back set
	wire [7:0] wr_data = ctrl_hit ? (cmd.data & ~CLR_MASK) : cmd.data;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shin        <= 16'h0000;
			shout       <= 16'h0000;
			bitcnt      <= GDC_CNT_RESET;
			load_arm    <= 1'b0;
			load_report <= 1'b0;
		end else begin
			// the read port needs one more edge after the eighth bit settles the address
			load_arm    <= ck_fall & (bitcnt == 5'h07);
			load_report <= load_arm;
			if (cs_fall) begin
				bitcnt <= GDC_CNT_RESET;
				shout  <= {GDC_STAT_TOP, flags, 8'h00}; // [RULE20] [RULE10]
			end else if (ck_fall) begin
				shin   <= {shin[14:0], di_s2}; // [RULE4] [RULE5]
				if (bitcnt != 5'h1f) bitcnt <= bitcnt + 5'h01;
			end else if (ck_rise) begin
				shout <= {shout[14:0], 1'b0}; // [RULE4] [RULE5]
			end
			// address known after 8 bits; report byte loaded before its first bit goes out
			if (load_report) shout[15:8] <= rdata; // [RULE9]
		end
	end

	// memory read port follows the address bits; old contents come out for writes
	gdc_regmem u_mem (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.clear_i (reg_clear),
		.we_i    (do_write),
		.waddr_i (cmd.addr),
		.wdata_i (wr_data),
		.raddr_i (shin[5:0]), // [RULE7]
		.rdata_o (rdata)
	);

	// ****************************************
	// latched faults and outputs
	// ****************************************
	logic frame_err;
	logic drv_en;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags     <= '0;
			frame_err <= 1'b0;
			drv_en    <= 1'b0;
		end else begin
			// new causes win over the clear in the same cycle
			flags <= (clr_cmd ? '0 : flags) | fc_s2; // [RULE19]
			if (reg_clear) frame_err <= 1'b0;
			else if (port_on & cs_rise & ~frame_ok) frame_err <= 1'b1; // [RULE6]
			else if (clr_cmd) frame_err <= 1'b0; // [RULE19]
			if (reg_clear) drv_en <= 1'b0;
			else if (do_write && ctrl_hit)
				drv_en <= cmd.data[GDC_DRV_ENABLE_BIT]; // [RULE15]
		end
	end

	wire drv_allow = PIN_VARIANT ? 1'b1 : drv_en; // [RULE16] [RULE15]
	wire gates_on  = (state == GDC_OPERATE) & drv_allow & ~kill; // [RULE17]

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sdo_o                <= 1'b0;
			sdo_oe_o             <= 1'b0;
			fault_flags_o        <= '0;
			frame_length_error_o <= 1'b0;
			state_o              <= GDC_SLEEP;
			core_active_o        <= 1'b0;
			charge_pump_on_o     <= 1'b0;
			gate_drive_on_o      <= 1'b0;
			gate_pulldown_o      <= 1'b1;
		end else begin
			// status msb stands from select fall; the first rise drives the msb again, each later rise launches the next bit
			if (cs_fall) sdo_o <= GDC_STAT_TOP[1]; // [RULE10]
			else if (ck_rise) sdo_o <= shout[15]; // [RULE4]
			sdo_oe_o             <= selected & port_on; // [RULE3]
			fault_flags_o        <= flags;
			frame_length_error_o <= frame_err;
			state_o              <= state;
			core_active_o        <= port_on; // [RULE13]
			charge_pump_on_o     <= (state == GDC_OPERATE); // [RULE13]
			gate_drive_on_o      <= gates_on;
			gate_pulldown_o      <= ~gates_on; // [RULE11] [RULE17]
		end
	end
endmodule

/* gdc_props.sv */
// checker: assertions on the serial port and power state outputs
`timescale 1ns/10ps
module gdc_props
	import gdc_pkg::*;
(
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	input wire logic       chip_select_n_i,
	input wire logic       sdo_o,
	input wire logic       sdo_oe_o,
	input wire logic       wake_pin_i,
	input wire logic       power_supply_ok_i,
	input wire logic       driver_kill_pin_i,
	input wire gdc_flags_t fault_flags_o,
	input wire logic       frame_length_error_o,
	input wire gdc_state_t state_o,
	input wire logic       core_active_o,
	input wire logic       charge_pump_on_o,
	input wire logic       gate_drive_on_o,
	input wire logic       gate_pulldown_o
);
	// ****************
	// properties
	// ****************
	// level inputs pass a 2-flop sync, so repetitions leave that lag
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_tri; chip_select_n_i[*5] |-> !sdo_oe_o; endproperty
	a_tri: assert property (p_tri) else $error("sdo driven while idle");
	property p_err; $rose(frame_length_error_o) |-> chip_select_n_i; endproperty
	a_err: assert property (p_err) else $error("frame error inside frame");
	property p_msb; $rose(sdo_oe_o) |-> ##[0:3] sdo_o; endproperty
	a_msb: assert property (p_msb) else $error("status msb not one");
	property p_slp; (state_o == GDC_SLEEP)[*2] |-> gate_pulldown_o && !gate_drive_on_o
		&& !charge_pump_on_o; endproperty
	a_slp: assert property (p_slp) else $error("sleep outputs wrong");
	property p_wake; !wake_pin_i[*6] |-> state_o == GDC_SLEEP; endproperty
	a_wake: assert property (p_wake) else $error("awake with wake low");
	property p_stby; (state_o == GDC_STANDBY)[*2] |-> core_active_o && !gate_drive_on_o
		&& !charge_pump_on_o; endproperty
	a_stby: assert property (p_stby) else $error("standby outputs wrong");
	property p_op; !power_supply_ok_i[*6] |-> state_o != GDC_OPERATE; endproperty
	a_op: assert property (p_op) else $error("operate without supply");
	property p_gate; gate_drive_on_o |-> state_o == GDC_OPERATE
		|| $past(state_o) == GDC_OPERATE; endproperty
	a_gate: assert property (p_gate) else $error("gates on outside operate");
	property p_kill; driver_kill_pin_i[*5] |-> !gate_drive_on_o && gate_pulldown_o; endproperty
	a_kill: assert property (p_kill) else $error("gates on while killed");
	property p_hold; $fell(|fault_flags_o) |-> $past(chip_select_n_i); endproperty
	a_hold: assert property (p_hold) else $error("flag dropped in frame");
endmodule

bind gdc_serial_ctrl gdc_props u_gdc_props (.*);

/* gdc_spi_host.sv */
// partner: serial controller model on mclk timing, 320 ns link clock
`timescale 1ns/10ps
module gdc_spi_host (
	input  wire logic mclk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      chip_select_n_o,
	output logic      sclk_o,
	output logic      sdi_o
);
	// ****************
	// frame driver
	// ****************
	// one select line, shared by the serial and pin variants in tb
	initial begin
		chip_select_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// nclk other than 16 is used on purpose to provoke a refusal
	task automatic xfer(input logic [15:0] w, input int nclk, output logic [15:0] r);
		r = '0;
		@(posedge mclk_i) chip_select_n_o <= 1'b0;
		repeat (8) @(posedge mclk_i);
		for (int i = 0; i < nclk; i++) begin
			sclk_o <= 1'b1;
			sdi_o <= w[15 - (i % 16)];
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b0;
			repeat (2) @(posedge mclk_i);
			@(negedge mclk_i);
			// a released line reads as junk, never as a held value
			r = {r[14:0], sdo_oe_i ? sdo_i : ~r[0]};
			repeat (2) @(posedge mclk_i);
		end
		chip_select_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (4) begin
			repeat (4) @(posedge mclk_i);
			sclk_o <= ~sclk_o;
		end
		repeat (6) @(posedge mclk_i);
	endtask
endmodule

/* tb.sv */
// testbench: frames, power states and gate drive control
`timescale 1ns/10ps
module tb;
	import gdc_pkg::*;
	logic        mclk_i = 1'b0, rst_n_i = 1'b0, cs_n, sclk, sdi, sdo, sdo_oe;
	logic        wake = 1'b0, lsup = 1'b0, psup = 1'b0, kill = 1'b0;
	logic        ferr, core, cp, gate, pd, gate_pin;
	gdc_flags_t  causes = '0, flags, f;
	gdc_state_t  state;
	logic [15:0] r;
	int          error_cnt = 0, num_checks = 0;
	always #20 mclk_i = ~mclk_i;
	gdc_serial_ctrl u_gdc_serial_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.chip_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
		.wake_pin_i(wake), .logic_supply_ok_i(lsup), .power_supply_ok_i(psup),
		.driver_kill_pin_i(kill), .fault_causes_i(causes), .fault_flags_o(flags),
		.frame_length_error_o(ferr), .state_o(state), .core_active_o(core),
		.charge_pump_on_o(cp), .gate_drive_on_o(gate), .gate_pulldown_o(pd));
	gdc_spi_host u_gdc_spi_host (.mclk_i(mclk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
		.chip_select_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
	// pin variant shares every input; only its gate enable is watched
	gdc_serial_ctrl #(.PIN_VARIANT(1'b1)) u_gdc_serial_ctrl_pin (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .chip_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(),
		.sdo_oe_o(), .wake_pin_i(wake), .logic_supply_ok_i(lsup), .power_supply_ok_i(psup),
		.driver_kill_pin_i(kill), .fault_causes_i(causes), .fault_flags_o(),
		.frame_length_error_o(), .state_o(), .core_active_o(), .charge_pump_on_o(),
		.gate_drive_on_o(gate_pin), .gate_pulldown_o());
	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic xf(input logic [15:0] w, input logic [15:0] exp, input int n = 16);
		u_gdc_spi_host.xfer(w, n, r);
		chk(r, exp);
	endtask
	task automatic lv(input logic [5:0] e);
		repeat (10) @(posedge mclk_i);
		chk({10'h0, state, core, cp, gate, pd}, {10'h0, e});
	endtask
	initial begin
		#1_000_000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		lv({GDC_SLEEP, 4'h1});
		wake <= 1'b1;
		lsup <= 1'b1;
		lv({GDC_WAKING, 4'h1});
		repeat (20) @(posedge mclk_i);
		lv({GDC_STANDBY, 4'h9});
		xf(16'h05a5, 16'hc000);
		xf(16'h4500, 16'hc0a5);
		xf(16'h055a, 16'hc0a5);
		xf(16'h0533, 16'h602d, 15);
		chk({15'h0, ferr}, 16'h0001);
		xf(16'h0701, 16'hc000);
		chk({15'h0, ferr}, 16'h0000);
		u_gdc_spi_host.xfer(16'h0577, 17, r);
		chk({15'h0, ferr}, 16'h0001);
		xf(16'h4500, 16'hc05a);
		for (int i = 0; i < 6; i++) begin
			f = gdc_flags_t'(6'h20 >> i);
			causes <= f;
			repeat (10) @(posedge mclk_i);
			causes <= '0;
			repeat (10) @(posedge mclk_i);
			chk({10'h0, flags}, {10'h0, f});
			xf(16'h4500, {2'h3, f, 8'h5a});
			xf(16'h0701, {2'h3, f, 8'h00});
			chk({10'h0, flags}, 16'h0000);
		end
		psup <= 1'b1;
		lv({GDC_OPERATE, 4'hd});
		chk({15'h0, gate_pin}, 16'h0001);
		xf(16'h0780, 16'hc000);
		lv({GDC_OPERATE, 4'he});
		kill <= 1'b1;
		lv({GDC_OPERATE, 4'hd});
		chk({15'h0, gate_pin}, 16'h0000);
		kill <= 1'b0;
		lv({GDC_OPERATE, 4'he});
		xf(16'h0700, 16'hc080);
		lv({GDC_OPERATE, 4'hd});
		wake <= 1'b0;
		lv({GDC_SLEEP, 4'h1});
		u_gdc_spi_host.xfer(16'h0511, 16, r);
		wake <= 1'b1;
		repeat (60) @(posedge mclk_i);
		xf(16'h4500, 16'hc000);
		end_sim();
	end
endmodule
